// file: inc/srr_pkg.sv
package srr_pkg;

    // ==================================================
    // clock and time conversion
    localparam int CLK_NS = 4;

    // least time, rounded up to whole cycles
    function automatic int srr_ceil_cyc(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction

    // longest time, rounded down, never below one cycle
    function automatic int srr_floor_cyc(input int ns);
        return (ns < CLK_NS) ? 1 : ns / CLK_NS;
    endfunction

    localparam int DSEL_NS       = 20;
    localparam int DSEL_CYC      = srr_ceil_cyc(DSEL_NS);
    localparam int ROT_WAIT_NS   = 180;
    localparam int ROT_WAIT_CYC  = srr_ceil_cyc(ROT_WAIT_NS);
    localparam int SH_MIN_NS     = 100;
    localparam int SH_MIN_CYC    = srr_ceil_cyc(SH_MIN_NS);
    localparam int SH_MAX_NS     = 200;
    localparam int SH_MAX_CYC    = srr_floor_cyc(SH_MAX_NS);
    localparam int AVG_NS        = 20;
    localparam int AVG_CYC       = srr_ceil_cyc(AVG_NS + 1);
    localparam int PREBUS_NS     = 5;
    localparam int PREBUS_CYC    = srr_floor_cyc(PREBUS_NS);
    localparam int CLKX_HALF_CYC = 4;
    localparam int SPI_HALF_CYC  = 4;
    localparam int LOAD_CYC      = 8;
    localparam int YSYNC_CYC     = 8;
    localparam int YCLK_ON       = 2;
    localparam int YCLK_OFF      = 6;

    // ==================================================
    // configuration word layout
    localparam int CFG_W         = 32;
    localparam int ADDR_W        = 10;
    localparam int PIX_W         = 11;
    localparam int DAC_W         = 7;
    localparam int CFG_YDIR      = 0;
    localparam int CFG_YADDR     = 1;
    localparam int CFG_AVG       = 11;
    localparam int CFG_SUB       = 12;
    localparam int CFG_XDIR      = 13;
    localparam int CFG_XADDR     = 14;
    localparam int CFG_NOUT      = 24;
    localparam int CFG_DAC       = 25;
    localparam logic [31:0] CFG_RST  = 32'h0000_0000;
    localparam logic [10:0] PIX_LAST = 11'h7ff;

    // ==================================================
    // sensor pin index in the synchroniser vector
    localparam int PIN_CLKX  = 0;
    localparam int PIN_SYNCX = 1;
    localparam int PIN_CLKY  = 2;
    localparam int PIN_SYNCY = 3;
    localparam int PIN_RDSEL = 4;
    localparam int PIN_CPRE  = 5;
    localparam int PIN_TRKN  = 6;
    localparam int PIN_AVG   = 7;
    localparam int PIN_PREA  = 8;
    localparam int PIN_PREB  = 9;
    localparam int PIN_SDAT  = 10;
    localparam int PIN_SCLK  = 11;
    localparam int PIN_SLOAD = 12;
    localparam int PIN_N     = 13;

    // ==================================================
    // controller registers (apb)
    localparam logic [7:0] REG_CFG     = 8'h00;
    localparam logic [7:0] REG_CTRL    = 8'h04;
    localparam logic [7:0] REG_SHLEN   = 8'h08;
    localparam logic [7:0] REG_LINELEN = 8'h0c;
    localparam logic [7:0] REG_STATUS  = 8'h10;
    localparam int CTL_GO_CFG  = 0;
    localparam int CTL_GO_LINE = 1;
    localparam int CTL_FRAME   = 2;
    localparam int CTL_SHORT   = 4;
    localparam int CTL_BUSPRE  = 5;
    localparam int CTL_AVG     = 6;
    localparam int ST_BUSY     = 0;
    localparam int ST_EOS      = 1;
    localparam int ST_EOL      = 2;
    localparam logic [7:0]  SHLEN_RST   = 8'h32;
    localparam logic [10:0] LINELEN_RST = 11'h400;

    // ==================================================
    // state types
    typedef enum logic [2:0] {
        C_IDLE, C_SHIFT, C_LOAD, C_YSYNC, C_LINE, C_AVG, C_XRUN
    } srr_cst_t;

    typedef struct packed {
        srr_cst_t    st;
        logic [7:0]  cnt;
        logic [4:0]  bit_i;
        logic [10:0] col;
        logic [31:0] cfg;
        logic [2:0]  mode;
        logic        frame;
        logic [7:0]  sh_len;
        logic [10:0] line_len;
        logic        eol_seen;
        logic        eos_s1, eos_s2, eol_s1, eol_s2;
        logic [31:0] prdata;
        logic        pslverr;
        logic        clock_x, sync_x, clock_y, sync_y;
        logic        rdsel, cpre, trk_n, avg, prebus;
        logic        sdat, sclk, sload;
    } srr_ctrl_t;

    typedef struct packed {
        logic [PIN_N-1:0] s1, s2, s3;
        logic [31:0]      shift;
        logic [31:0]      cfg;
        logic [10:0]      row;
        logic [10:0]      col;
        logic             run;
        logic [10:0]      pix_a, pix_b;
        logic             held;
        logic [10:0]      held_row;
        logic             avg_app;
        logic             eol;
    } srr_dev_t;

endpackage

// file: inc/srr_link_if.sv
`timescale 1ns/1ns
// wires between timing controller and sensor
interface srr_link_if;
    logic clock_x;
    logic sync_x;
    logic clock_y;
    logic sync_y;
    logic row_deselect;
    logic column_precharge;
    logic column_track_hold_n;
    logic volt_avg;
    logic output_bus_precharge_a;
    logic output_bus_precharge_b;
    logic cfg_data;
    logic cfg_clock;
    logic cfg_load;
    logic end_of_shift;
    logic end_of_line;

    modport ctrl (
        output clock_x, sync_x, clock_y, sync_y, row_deselect, column_precharge,
        output column_track_hold_n, volt_avg, output_bus_precharge_a,
        output output_bus_precharge_b, cfg_data, cfg_clock, cfg_load,
        input  end_of_shift, end_of_line
    );

    modport sens (
        input  clock_x, sync_x, clock_y, sync_y, row_deselect, column_precharge,
        input  column_track_hold_n, volt_avg, output_bus_precharge_a,
        input  output_bus_precharge_b, cfg_data, cfg_clock, cfg_load,
        output end_of_shift, end_of_line
    );
endinterface

// file: rtl/srr_ctrl.sv
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns
module srr_ctrl
    import srr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    srr_link_if.ctrl         lk
);

    srr_ctrl_t s, n;
    logic      wr;
    logic      short_m;
    logic [7:0] last;
    logic [31:0] sent;

    // word actually shifted: odd x start forced even when subsampling
    function automatic logic [31:0] even_fix(input logic [31:0] c);
        even_fix = c;
        if (c[CFG_SUB])
            even_fix[CFG_XADDR] = 1'b0;
    endfunction

    // ==================================================
    // next state
    always_comb begin
        n = s;
        wr = psel && penable && pwrite;
        short_m = s.mode[CTL_SHORT-4];
        last = short_m ? s.sh_len - 8'h01 : 8'(DSEL_CYC + ROT_WAIT_CYC - 1);
        n.eos_s1 = lk.end_of_shift;
        n.eos_s2 = s.eos_s1;
        n.eol_s1 = lk.end_of_line;
        n.eol_s2 = s.eol_s1;
        // read data prepared in setup cycle
        if (psel && !penable) begin
            n.prdata = 32'h0;
            n.pslverr = 1'b0;
            case (paddr)
                REG_CFG:     n.prdata = s.cfg;
                REG_CTRL:    n.prdata = {25'h0, s.mode, 1'b0, s.frame, 2'h0};
                REG_SHLEN:   n.prdata = {24'h0, s.sh_len};
                REG_LINELEN: n.prdata = {21'h0, s.line_len};
                REG_STATUS:  n.prdata = {29'h0, s.eol_seen, s.eos_s2, s.st != C_IDLE};
                default:     n.pslverr = 1'b1;
            endcase
        end
        // register writes, go bits included, act only when idle
        if (wr && s.st == C_IDLE) begin
            case (paddr)
                REG_CFG: n.cfg = pwdata;
                REG_CTRL: begin
                    n.mode = pwdata[CTL_AVG:CTL_SHORT];
                    n.frame = pwdata[CTL_FRAME];
                    n.cnt = 8'h00;
                    if (pwdata[CTL_GO_CFG]) begin
                        n.st = C_SHIFT;
                        n.bit_i = 5'h00;
                    end else if (pwdata[CTL_GO_LINE]) begin
                        n.st = pwdata[CTL_FRAME] ? C_YSYNC : C_LINE;
                    end
                end
                REG_SHLEN: begin
                    n.sh_len = pwdata[7:0];
                    if (pwdata[7:0] < 8'(SH_MIN_CYC))
                        n.sh_len = 8'(SH_MIN_CYC);
                    if (pwdata[7:0] > 8'(SH_MAX_CYC))
                        n.sh_len = 8'(SH_MAX_CYC);
                end
                REG_LINELEN: n.line_len = pwdata[10:0];
                default: ;
            endcase
        end
        // sticky end-of-line, write one to clear, set wins
        if (wr && paddr == REG_STATUS && pwdata[ST_EOL])
            n.eol_seen = 1'b0;
        if (s.eol_s2)
            n.eol_seen = 1'b1;
        // sequencer
        case (s.st)
            C_IDLE: ;
            C_SHIFT: begin
                n.cnt = s.cnt + 8'h01;
                if (s.cnt == 8'(2 * SPI_HALF_CYC - 1)) begin
                    n.cnt = 8'h00;
                    n.bit_i = s.bit_i + 5'h01;
                    if (s.bit_i == 5'h1f)
                        n.st = C_LOAD;
                end
            end
            C_LOAD: begin
                n.cnt = s.cnt + 8'h01;
                if (s.cnt == 8'(LOAD_CYC - 1))
                    n.st = C_IDLE;
            end
            C_YSYNC: begin
                n.cnt = s.cnt + 8'h01;
                if (s.cnt == 8'(YSYNC_CYC - 1)) begin
                    n.cnt = 8'h00;
                    n.st = C_LINE;
                end
            end
            C_LINE: begin
                n.cnt = s.cnt + 8'h01;
                if (s.cnt == last) begin
                    n.cnt = 8'h00;
                    n.col = 11'h000;
                    n.st = (short_m && s.mode[CTL_AVG-4]) ? C_AVG : C_XRUN;
                end
            end
            C_AVG: begin
                n.cnt = s.cnt + 8'h01;
                if (s.cnt == 8'(AVG_CYC)) begin
                    n.cnt = 8'h00;
                    n.st = C_XRUN;
                end
            end
            C_XRUN: begin
                n.cnt = s.cnt + 8'h01;
                if (s.cnt == 8'(2 * CLKX_HALF_CYC - 1)) begin
                    n.cnt = 8'h00;
                    n.col = s.col + 11'h001;
                    if (s.col + 11'h001 >= s.line_len)
                        n.st = C_IDLE;
                end
            end
            default: n.st = C_IDLE;
        endcase
        // pins decoded from the next state, then registered
        n.sclk = n.st == C_SHIFT && n.cnt >= 8'(SPI_HALF_CYC);
        sent = even_fix(n.cfg);
        n.sdat = n.st == C_SHIFT && sent[n.bit_i];
        n.sload = n.st == C_LOAD;
        n.sync_y = n.st == C_YSYNC;
        n.clock_y = (n.st == C_YSYNC && n.cnt >= 8'(YCLK_ON) && n.cnt < 8'(YCLK_OFF))
                  || (n.st == C_LINE && !n.frame && n.cnt < 8'(DSEL_CYC));
        n.rdsel = n.st == C_LINE && n.cnt < 8'(DSEL_CYC);
        n.cpre = n.rdsel;
        n.prebus = n.st == C_LINE && n.mode[CTL_BUSPRE-4]
                 && n.cnt < 8'(PREBUS_CYC);
        // standard: held low; shortened: idle high, low pulse of sh_len
        n.trk_n = n.mode[CTL_SHORT-4]
                ? !(n.st == C_LINE && n.cnt < n.sh_len) : 1'b0;
        n.avg = n.st == C_AVG && n.cnt != 8'h00;
        // first pixel not before the wait after the pulses in standard mode; shortened mode waits sh_len cycles from line start, plus the C_AVG state when averaging
        n.clock_x = n.st == C_XRUN && n.cnt >= 8'(CLKX_HALF_CYC);
        n.sync_x = n.st == C_XRUN && n.col == 11'h000;
    end

    // ==================================================
    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
            s.st <= C_IDLE;
            s.sh_len <= SHLEN_RST;
            s.line_len <= LINELEN_RST;
            s.cfg <= CFG_RST;
        end else begin
            s <= n;
        end
    end

    // ==================================================
    // outputs
    assign prdata = s.prdata;
    assign pslverr = s.pslverr;
    assign pready = 1'b1;
    assign lk.clock_x = s.clock_x;
    assign lk.sync_x = s.sync_x;
    assign lk.clock_y = s.clock_y;
    assign lk.sync_y = s.sync_y;
    assign lk.row_deselect = s.rdsel;
    assign lk.column_precharge = s.cpre;
    assign lk.column_track_hold_n = s.trk_n;
    assign lk.volt_avg = s.avg;
    assign lk.output_bus_precharge_a = s.prebus;
    assign lk.output_bus_precharge_b = s.prebus;
    assign lk.cfg_data = s.sdat;
    assign lk.cfg_clock = s.sclk;
    assign lk.cfg_load = s.sload;

endmodule

// file: rtl/srr_sensor.sv
`timescale 1ns/1ns
// Function
// - controller pulses deselect and precharge about 20 ns
// - controller waits 180 ns before first pixel in standard mode only
// - standard mode holds track control low
// - shortened mode: one 100-200 ns track pulse
// - sensor tracks while active, stores at end
// - averaging pulse after track pulse, before readout
// - optional output bus precharge pulse of at most 5 ns (one cycle)
// - bit 0 vertical direction, bits 1-10 start
// - bit 11 averaging, bit 12 subsampling enable
// - bit 13 horizontal direction, bits 14-23 start
// - bit 24 selects one or two outputs
// - bits 25-31 set dac level
// - all-zero word reads from pixel 0,0
// - even horizontal start when subsampling
// - serial shift in, load moves word active
// - end-of-shift output shows shift chain
// - end-of-line output at last column
// - line sync reloads horizontal start address
// - horizontal start pixel is address times two
// - two pixels per column clock period
// - frame sync dominates; row clock advances line
module srr_sensor
    import srr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    srr_link_if.sens         lk,
    output logic             cfg_y_dir,
    output logic [10:0]      cfg_y_start,
    output logic             cfg_avg_en,
    output logic             cfg_sub_en,
    output logic             cfg_x_dir,
    output logic [10:0]      cfg_x_start,
    output logic             cfg_two_outputs,
    output logic [6:0]       cfg_dac_level,
    output logic [10:0]      row_addr,
    output logic             pixel_valid,
    output logic [10:0]      pixel_a_addr,
    output logic [10:0]      pixel_b_addr,
    output logic             pixel_b_valid,
    output logic             track_held,
    output logic [10:0]      held_row,
    output logic             avg_applied,
    output logic             column_reset,
    output logic             bus_preset
);

    srr_dev_t         s, n;
    logic [PIN_N-1:0] pins;
    logic [PIN_N-1:0] rise;
    logic [PIN_N-1:0] fall;
    logic [PIN_N-1:0] lvl;
    logic [10:0]      step;
    logic [10:0]      ncol;

    // ==================================================
    // helpers

    // start pixel from a 10-bit address field
    function automatic logic [10:0] start_pix(input logic [31:0] c,
                                              input int lsb);
        start_pix = {c[lsb +: ADDR_W], 1'b0};
    endfunction

    // column advance per column clock period
    function automatic logic [10:0] col_step(input logic [31:0] c);
        col_step = c[CFG_SUB] ? 11'h004 : 11'h002;
    endfunction

    // neighbour pixel of a pair in scan direction
    function automatic logic [10:0] pair_pix(input logic [31:0] c,
                                             input logic [10:0] col);
        if (c[CFG_XDIR])
            pair_pix = col - 11'h001;
        else
            pair_pix = col + 11'h001;
    endfunction

    // true when the current pair is the last one of the line
    function automatic logic last_col(input logic [31:0] c,
                                      input logic [10:0] col);
        logic [11:0] ahead;
        ahead = {1'b0, col} + {1'b0, col_step(c)};
        if (c[CFG_XDIR])
            last_col = col < col_step(c);
        else
            last_col = ahead > {1'b0, PIX_LAST};
    endfunction

    // ==================================================
    // pin gathering
    always_comb begin
        pins = '0;
        pins[PIN_CLKX] = lk.clock_x;
        pins[PIN_SYNCX] = lk.sync_x;
        pins[PIN_CLKY] = lk.clock_y;
        pins[PIN_SYNCY] = lk.sync_y;
        pins[PIN_RDSEL] = lk.row_deselect;
        pins[PIN_CPRE] = lk.column_precharge;
        pins[PIN_TRKN] = lk.column_track_hold_n;
        pins[PIN_AVG] = lk.volt_avg;
        pins[PIN_PREA] = lk.output_bus_precharge_a;
        pins[PIN_PREB] = lk.output_bus_precharge_b;
        pins[PIN_SDAT] = lk.cfg_data;
        pins[PIN_SCLK] = lk.cfg_clock;
        pins[PIN_SLOAD] = lk.cfg_load;
    end

    // edges and levels only from the second stage on
    assign lvl = s.s2;
    assign rise = s.s2 & ~s.s3;
    assign fall = ~s.s2 & s.s3;
    assign step = col_step(s.cfg);

    // ==================================================
    // next state
    always_comb begin
        n = s;
        ncol = s.col;
        // two-stage synchroniser, then edge history
        n.s1 = pins;
        n.s2 = s.s1;
        n.s3 = s.s2;

        // serial configuration chain, first bit ends at bit 0
        if (rise[PIN_SCLK])
            n.shift = {lvl[PIN_SDAT], s.shift[31:1]};
        // load copies the chain into the active word
        if (rise[PIN_SLOAD])
            n.cfg = s.shift;

        // vertical addressing, frame sync dominates
        if (lvl[PIN_SYNCY]) begin
            n.row = start_pix(s.cfg, CFG_YADDR);
        end else if (rise[PIN_CLKY]) begin
            if (s.cfg[CFG_YDIR])
                n.row = s.row - 11'h001;
            else
                n.row = s.row + 11'h001;
        end

        // horizontal addressing
        if (lvl[PIN_SYNCX]) begin
            ncol = start_pix(s.cfg, CFG_XADDR);
            n.col = ncol;
            // sync edge drops the old run, first clock edge starts the new one
            n.run = (s.run && !rise[PIN_SYNCX]) || rise[PIN_CLKX];
        end else if (rise[PIN_CLKX] && s.run) begin
            if (last_col(s.cfg, s.col)) begin
                n.run = 1'b0;
            end else if (s.cfg[CFG_XDIR]) begin
                ncol = s.col - step;
                n.col = ncol;
            end else begin
                ncol = s.col + step;
                n.col = ncol;
            end
        end
        n.eol = n.run && last_col(s.cfg, n.col);

        // pixel selection; with one output, from the column clock level
        if (s.cfg[CFG_NOUT]) begin
            n.pix_a = n.col;
            n.pix_b = pair_pix(s.cfg, n.col);
        end else begin
            // high selects first pixel, low the next one
            n.pix_a = lvl[PIN_CLKX] ? n.col : pair_pix(s.cfg, n.col);
            n.pix_b = 11'h000;
        end

        // column sample and hold: track while low, store on rise
        if (fall[PIN_TRKN]) begin
            n.held = 1'b0;
            n.avg_app = 1'b0;
        end
        if (rise[PIN_TRKN]) begin
            n.held = 1'b1;
            n.held_row = s.row;
        end

        // averaging acts on held data only when enabled
        if (rise[PIN_AVG] && s.held && s.cfg[CFG_AVG])
            n.avg_app = 1'b1;
    end

    // ==================================================
    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
            s.cfg <= CFG_RST;
        end else begin
            s <= n;
        end
    end

    // ==================================================
    // configuration fields
    assign cfg_y_dir = s.cfg[CFG_YDIR];
    assign cfg_y_start = start_pix(s.cfg, CFG_YADDR);
    assign cfg_avg_en = s.cfg[CFG_AVG];
    assign cfg_sub_en = s.cfg[CFG_SUB];
    assign cfg_x_dir = s.cfg[CFG_XDIR];
    assign cfg_x_start = start_pix(s.cfg, CFG_XADDR);
    assign cfg_two_outputs = s.cfg[CFG_NOUT];
    assign cfg_dac_level = s.cfg[CFG_DAC +: DAC_W];

    // ==================================================
    // readout state
    assign row_addr = s.row;
    assign pixel_valid = s.run;
    assign pixel_a_addr = s.pix_a;
    assign pixel_b_addr = s.pix_b;
    assign pixel_b_valid = s.run && s.cfg[CFG_NOUT];
    assign track_held = s.held;
    assign held_row = s.held_row;
    assign avg_applied = s.avg_app;

    // column reset and bus preset follow synced levels
    assign column_reset = lvl[PIN_RDSEL] | lvl[PIN_CPRE];
    assign bus_preset = lvl[PIN_PREA] & lvl[PIN_PREB];

    // ==================================================
    // test flags
    assign lk.end_of_shift = s.shift[0];
    assign lk.end_of_line = s.eol;

endmodule

// file: sim/srr_chk.sv
`timescale 1ns/1ns
// ==================================================
// link timing checker
module srr_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clock_x,
    input wire logic row_deselect,
    input wire logic column_precharge,
    input wire logic column_track_hold_n,
    input wire logic volt_avg,
    input wire logic output_bus_precharge_a,
    input wire logic output_bus_precharge_b,
    input wire logic cfg_clock,
    input wire logic cfg_load
);
    logic [7:0] gap_q, trk_q;
    logic [5:0] nclk_q;
    logic       trk_p_q, sck_p_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // cycles since deselect, track pulse length, shift clocks since load
    always_ff @(posedge clk) begin
        trk_p_q <= column_track_hold_n;
        sck_p_q <= cfg_clock;
        if (!rst_n || row_deselect) gap_q <= 8'h00;
        else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
        if (!rst_n || column_track_hold_n) trk_q <= 8'h00;
        else if (trk_p_q && column_precharge) trk_q <= 8'h01;
        else if (trk_q != 8'h00 && trk_q != 8'hff) trk_q <= trk_q + 8'h01;
        if (!rst_n || cfg_load) nclk_q <= 6'h00;
        else if (cfg_clock && !sck_p_q) nclk_q <= nclk_q + 6'h01;
    end

    // ==================================================
    // properties
    chk_dsel_pulse: assert property ($rose(row_deselect) |->
        (row_deselect && column_precharge)[*5] ##1 !row_deselect) else $error("deselect pulse");
    chk_rot_wait: assert property ($rose(clock_x) && !column_track_hold_n |->
        gap_q >= 8'h2d) else $error("row wait short");
    chk_track_start: assert property ($fell(column_track_hold_n) |->
        $rose(column_precharge) && row_deselect) else $error("track start");
    chk_track_len: assert property ($rose(column_track_hold_n) && trk_q != 8'h00 |->
        trk_q inside {[8'h19:8'h32]}) else $error("track length");
    chk_avg_pulse: assert property ($rose(volt_avg) |-> $past(column_track_hold_n)
        ##0 (volt_avg && !clock_x)[*6] ##1 !volt_avg) else $error("averaging pulse");
    chk_bus_pre: assert property ($rose(output_bus_precharge_a) |->
        output_bus_precharge_b ##1 !output_bus_precharge_a) else $error("bus precharge");
    chk_load_hold: assert property ($rose(cfg_load) |->
        (cfg_load && !cfg_clock)[*8] ##1 !cfg_load) else $error("load pulse");
    chk_shift_count: assert property ($rose(cfg_load) |-> nclk_q == 6'h20)
        else $error("shift clock count");

    cov_load: cover property ($rose(cfg_load));
    cov_track: cover property ($fell(column_track_hold_n));
    cov_avg: cover property ($rose(volt_avg));
endmodule

// file: sim/srr_tb_top.sv
`timescale 1ns/1ns
`define CK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module srr_tb_top
    import srr_pkg::*;
;
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic        y_dir, avg_en, sub_en, x_dir, two, held, avg_app, pv, pbv;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, w;
    logic [10:0] y_st, x_st, row, hrow, pa, pb;
    logic [6:0]  dac;
    logic [33:0] cfg_got;
    logic [31:0] modes [4] = '{32'h06, 32'h22, 32'h12, 32'h72};
    int          num_errors = 0, n_compared = 0, seed = 10891, erow = 0, i;

    assign cfg_got = {y_dir, y_st, avg_en, sub_en, x_dir, x_st, two, dac};
    initial forever #2 clk = ~clk;

    srr_link_if lk ();
    srr_ctrl u_srr_ctrl (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lk(lk));
    srr_sensor u_srr_sensor (.clk(clk), .rst_n(rst_n), .lk(lk), .cfg_y_dir(y_dir),
        .cfg_y_start(y_st), .cfg_avg_en(avg_en), .cfg_sub_en(sub_en), .cfg_x_dir(x_dir),
        .cfg_x_start(x_st), .cfg_two_outputs(two), .cfg_dac_level(dac), .row_addr(row),
        .pixel_valid(pv), .pixel_a_addr(pa), .pixel_b_addr(pb), .pixel_b_valid(pbv),
        .track_held(held), .held_row(hrow), .avg_applied(avg_app), .column_reset(),
        .bus_preset());
    srr_chk u_srr_chk (.clk(clk), .rst_n(rst_n), .clock_x(lk.clock_x),
        .row_deselect(lk.row_deselect), .column_precharge(lk.column_precharge),
        .column_track_hold_n(lk.column_track_hold_n), .volt_avg(lk.volt_avg),
        .output_bus_precharge_a(lk.output_bus_precharge_a),
        .output_bus_precharge_b(lk.output_bus_precharge_b), .cfg_clock(lk.cfg_clock),
        .cfg_load(lk.cfg_load));

    // ==================================================
    // model and bus tasks
    function automatic logic [33:0] dec(input logic [31:0] v);
        logic [9:0] x;
        x = v[23:14] & {9'h1ff, ~v[12]};
        return {v[0], v[10:1], 1'b0, v[11], v[12], v[13], x, 1'b0, v[24], v[31:25]};
    endfunction

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 50) begin num_errors++; results(); end
        @(posedge clk);
    endtask

    // poll busy, bounded
    task automatic idle;
        for (int k = 0; k < 400; k++) begin
            apb(1'b0, REG_STATUS, 32'h0);
            if (rd[ST_BUSY] === 1'b0) return;
        end
        num_errors++;
        results();
    endtask

    // ==================================================
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, REG_SHLEN, 32'h0);
        `CK(rd, {24'h0, SHLEN_RST})
        apb(1'b1, 8'h20, 32'hffff_ffff);
        `CK({er, rd}, 33'h1_0000_0000)
        $display("register test done");
        for (i = 0; i < 4; i++) begin
            w = (i == 0) ? 32'h0 : $random(seed);
            if (i == 2) w[14:12] = 3'h5;
            if (i == 3) w[23:12] = 12'hff8; // start two pairs before line end
            apb(1'b1, REG_CFG, w);
            apb(1'b1, REG_CTRL, 32'h1);
            apb(1'b1, REG_CFG, ~w);  // refused while busy
            idle();
            `CK(cfg_got, dec(w))
            `CK(rd[ST_EOS], w[0])
        end
        $display("config test done");
        apb(1'b1, REG_LINELEN, 32'h2);
        apb(1'b1, REG_SHLEN, 32'h19);
        foreach (modes[m]) begin
            apb(1'b1, REG_STATUS, 32'h4);
            apb(1'b1, REG_CTRL, modes[m]);
            idle();
            apb(1'b0, REG_STATUS, 32'h0); // flag sync lags busy by a few cycles
            erow = modes[m][CTL_FRAME] ? {w[10:1], 1'b0} : (w[0] ? erow - 1 : erow + 1);
            `CK(avg_app, modes[m][CTL_AVG] & w[11])
            `CK({pv, pbv, pa}, {1'b1, w[24], w[24] ? 11'h7fe : 11'h7ff})
            `CK(pb, w[24] ? 11'h7ff : 11'h000)
            `CK(rd[ST_EOL], 1'b1)
            `CK(row, erow[10:0])
            if (modes[m][CTL_SHORT]) `CK({held, hrow}, {1'b1, erow[10:0]})
        end
        $display("line test done");
        results();
    end
endmodule
